// File: rtl/ddi_ctrl.sv
// Init controller end: drives reset, CKE, ODT and commands to a DDR3
// device, runs power-up, supply-switch and single mode-register writes.
// Assumes a 125 MHz MCLK_IN; the link clock CK is MCLK_IN divided by two.
`include "ddi_cfg.svh"
`timescale 1ns/10ps
module ddi_ctrl
  import ddi_pkg::*;
#(
  parameter int RST_CYC = `DDI_CYC_UP(`DDI_T_RST_NS),
  parameter int CKEL_CYC = `DDI_CYC_UP(`DDI_T_CKEL_NS) - `DDI_CK_DIV
)
(
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic RSTN_IN,
  // Register port
  input wire logic [2:0] ADDR_IN,
  input wire logic [15:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [15:0] RDATA_OUT,
  // Status
  output logic READY_OUT,
  // Memory link
  ddi_if.ctrl link
);

  // ----------------------------------------------------------------------
  // Wait counts in system clock cycles
  // ----------------------------------------------------------------------
  localparam int XPR_CYC = `DDI_CYC_UP(`DDI_T_XPR_NS);
  localparam int MRD_CYC = `DDI_NCK_MRD * `DDI_CK_DIV;
  localparam int MOD_CYC = `DDI_NCK_MOD * `DDI_CK_DIV;
  localparam int LOCK_CYC = ((`DDI_NCK_DLLK > `DDI_NCK_ZQINIT) ?
    `DDI_NCK_DLLK : `DDI_NCK_ZQINIT) * `DDI_CK_DIV;

  ddi_state_t state_reg, state_next;
  logic [1:0] step_reg, step_next;
  logic ck_reg, rstn_reg, rstn_next, cke_reg, cke_next, odt_reg;
  logic [3:0] cmd_reg, cmd_next;
  logic [2:0] ba_reg, ba_next;
  logic [13:0] a_reg, a_next;
  logic [13:0] mr_reg [4];
  logic init_req_reg, vsw_req_reg, vok_reg, umrs_req_reg, odt_en_reg;
  logic [1:0] tgt_reg;
  logic [1:0] mr_sel;
  logic last_step, tmr_load, tmr_done, wr_ctrl, taking;
  logic [16:0] tmr_val;

  // ----------------------------------------------------------------------
  // Link clock divider
  // ----------------------------------------------------------------------
  // Pins other than ODT change only when CK falls, so the memory sees them settled
  always_ff @(posedge MCLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      ck_reg <= 1'b0;
    else
      ck_reg <= ~ck_reg;
  end

  // ----------------------------------------------------------------------
  // Sequence control
  // ----------------------------------------------------------------------
  ddi_tmr u_tmr
  (
    .clk_in(MCLK_IN),
    .rstn_in(RSTN_IN),
    .load_in(tmr_load),
    .val_in(tmr_val),
    .en_in(1'b1),
    .done_out(tmr_done)
  );

  // Fixed init order of mode registers
  assign mr_sel = (step_reg == 2'h0) ? 2'h2 : (step_reg == 2'h1) ? 2'h3 :
    (step_reg == 2'h2) ? 2'h1 : 2'h0;
  assign last_step = (step_reg == 2'h3);
  assign wr_ctrl = WR_IN && (ADDR_IN == `DDI_RA_CTRL);
  assign taking = ck_reg && !wr_ctrl;

  // Next state, pin values and timer loads; acts once per CK period
  always_comb
  begin
    state_next = state_reg;
    step_next = step_reg;
    rstn_next = rstn_reg;
    cke_next = cke_reg;
    cmd_next = DDI_CMD_NOP;
    ba_next = ba_reg;
    a_next = a_reg;
    tmr_load = 1'b0;
    tmr_val = 17'h00000;
    if (taking && init_req_reg)
    begin
      state_next = DDI_ST_BOOT;
    end
    else if (taking)
    begin
      unique case (state_reg)
        DDI_ST_BOOT:
        begin
          rstn_next = 1'b0;
          cke_next = 1'b0;
          cmd_next = DDI_CMD_DES;
          tmr_load = 1'b1;
          tmr_val = 17'(RST_CYC);
          state_next = DDI_ST_RST;
        end
        DDI_ST_RST:
        begin
          cmd_next = DDI_CMD_DES;
          if (tmr_done)
          begin
            rstn_next = 1'b1;
            tmr_load = 1'b1;
            tmr_val = 17'(CKEL_CYC);
            state_next = DDI_ST_CKEL;
          end
        end
        DDI_ST_CKEL:
        begin
          if (tmr_done)
          begin
            cke_next = 1'b1;
            tmr_load = 1'b1;
            tmr_val = 17'(XPR_CYC);
            state_next = DDI_ST_XPR;
          end
        end
        DDI_ST_XPR:
        begin
          step_next = 2'h0;
          if (tmr_done)
            state_next = DDI_ST_MRS;
        end
        DDI_ST_MRS:
        begin
          cmd_next = DDI_CMD_MRS;
          ba_next = {1'b0, mr_sel};
          a_next = mr_reg[mr_sel];
          if (mr_sel == 2'h0)
            a_next[`DDI_DLLRST_BIT] = 1'b1;
          tmr_load = 1'b1;
          tmr_val = last_step ? 17'(MOD_CYC) : 17'(MRD_CYC);
          state_next = DDI_ST_MRW;
        end
        DDI_ST_MRW:
        begin
          if (tmr_done && last_step)
            state_next = DDI_ST_ZQ;
          else if (tmr_done)
          begin
            step_next = step_reg + 2'h1;
            state_next = DDI_ST_MRS;
          end
        end
        DDI_ST_ZQ:
        begin
          cmd_next = DDI_CMD_ZQCL;
          a_next = 14'h0000;
          a_next[`DDI_ZQL_BIT] = 1'b1;
          tmr_load = 1'b1;
          tmr_val = 17'(LOCK_CYC);
          state_next = DDI_ST_ZQW;
        end
        DDI_ST_ZQW:
        begin
          if (tmr_done)
            state_next = DDI_ST_RDY;
        end
        DDI_ST_RDY:
        begin
          // Idle here means no bursts and all banks precharged
          if (vsw_req_reg)
            state_next = DDI_ST_VSW;
          else if (umrs_req_reg)
          begin
            cmd_next = DDI_CMD_MRS;
            ba_next = {1'b0, tgt_reg};
            a_next = mr_reg[tgt_reg];
            tmr_load = 1'b1;
            tmr_val = 17'(MOD_CYC);
            state_next = DDI_ST_UMW;
          end
        end
        DDI_ST_VSW:
        begin
          // NOPs only until software reports the new supply stable
          if (vok_reg)
          begin
            step_next = 2'h3;
            state_next = DDI_ST_MRS;
          end
        end
        DDI_ST_UMW:
        begin
          if (tmr_done)
            state_next = DDI_ST_RDY;
        end
        default:
          state_next = DDI_ST_BOOT;
      endcase
    end
  end

  // State registers
  always_ff @(posedge MCLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      state_reg <= DDI_ST_BOOT;
      step_reg <= 2'h0;
    end
    else
    begin
      state_reg <= state_next;
      step_reg <= step_next;
    end
  end

  // ----------------------------------------------------------------------
  // Link pins
  // ----------------------------------------------------------------------
  // CKE drops again only when a re-init passes DDI_ST_BOOT, so power-down cannot follow an MRS early
  always_ff @(posedge MCLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      rstn_reg <= 1'b0;
      cke_reg <= 1'b0;
      odt_reg <= 1'b0;
      cmd_reg <= DDI_CMD_DES;
      ba_reg <= 3'h0;
      a_reg <= 14'h0000;
    end
    else
    begin
      rstn_reg <= rstn_next;
      cke_reg <= cke_next;
      odt_reg <= odt_en_reg && (state_next == DDI_ST_RDY) &&
        (state_reg == DDI_ST_RDY);
      cmd_reg <= ck_reg ? cmd_next : cmd_reg;
      ba_reg <= ba_next;
      a_reg <= a_next;
    end
  end

  assign link.ck = ck_reg;
  assign link.reset_n = rstn_reg;
  assign link.cke = cke_reg;
  assign link.odt = odt_reg;
  assign link.cmd = cmd_reg;
  assign link.ba = ba_reg;
  assign link.a = a_reg;

  // ----------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------
  // Requests are sticky; a write that sets one wins over its clear
  always_ff @(posedge MCLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      init_req_reg <= 1'b0;
      vsw_req_reg <= 1'b0;
      vok_reg <= 1'b0;
      umrs_req_reg <= 1'b0;
      tgt_reg <= 2'h0;
      odt_en_reg <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      init_req_reg <= init_req_reg | WDATA_IN[`DDI_CTRL_INIT];
      vsw_req_reg <= vsw_req_reg | WDATA_IN[`DDI_CTRL_VSW];
      vok_reg <= vok_reg | WDATA_IN[`DDI_CTRL_VOK];
      umrs_req_reg <= umrs_req_reg | WDATA_IN[`DDI_CTRL_UMRS];
      tgt_reg <= WDATA_IN[`DDI_CTRL_TGT +: 2];
      odt_en_reg <= WDATA_IN[`DDI_CTRL_ODT];
    end
    else if (ck_reg)
    begin
      if (init_req_reg)
        init_req_reg <= 1'b0;
      if (state_reg == DDI_ST_RDY && vsw_req_reg)
        vsw_req_reg <= 1'b0;
      else if (state_reg == DDI_ST_RDY)
        umrs_req_reg <= 1'b0;
      if (state_reg == DDI_ST_VSW && vok_reg)
        vok_reg <= 1'b0;
    end
  end

  // Mode register images, one word each
  always_ff @(posedge MCLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      mr_reg <= '{default: `DDI_MR_RST};
    else if (WR_IN && ADDR_IN >= `DDI_RA_MR0 && ADDR_IN < `DDI_RA_STAT)
      mr_reg[2'(ADDR_IN - `DDI_RA_MR0)] <= WDATA_IN[13:0];
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge MCLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      RDATA_OUT <= 16'h0000;
      READY_OUT <= 1'b0;
    end
    else
    begin
      READY_OUT <= (state_next == DDI_ST_RDY);
      if (!RD_IN)
        RDATA_OUT <= 16'h0000;
      else if (ADDR_IN == `DDI_RA_STAT)
        RDATA_OUT <= {10'h000, step_reg, state_reg};
      else if (ADDR_IN >= `DDI_RA_MR0 && ADDR_IN < `DDI_RA_STAT)
        RDATA_OUT <= {2'h0, mr_reg[2'(ADDR_IN - `DDI_RA_MR0)]};
      else if (ADDR_IN == `DDI_RA_CTRL)
        RDATA_OUT <= {9'h000, odt_en_reg, tgt_reg, umrs_req_reg, vok_reg,
          vsw_req_reg, init_req_reg};
      else
        RDATA_OUT <= 16'h0000;
    end
  end

endmodule // ddi_ctrl

// File: rtl/ddi_cfg.svh
// Timing counts, register offsets and field positions for the DDR3 init
// controller and its memory-device end.
// Assumes a 125 MHz system clock on both ends.
`ifndef DDI_CFG_SVH
`define DDI_CFG_SVH

// ----------------------------------------------------------------------
// Clocking
// ----------------------------------------------------------------------
`define DDI_CLK_NS 8
`define DDI_CK_DIV 2
`define DDI_CYC_UP(ns) (((ns) + `DDI_CLK_NS - 1) / `DDI_CLK_NS)
`define DDI_CYC_DN(ns) ((ns) / `DDI_CLK_NS)

// ----------------------------------------------------------------------
// Timing figures (times in ns, others in link clock cycles)
// ----------------------------------------------------------------------
`define DDI_T_RST_NS 200000
`define DDI_T_CKEL_NS 500000
`define DDI_T_XPR_NS 170
`define DDI_NCK_MRD 4
`define DDI_NCK_MOD 12
`define DDI_NCK_DLLK 512
`define DDI_NCK_ZQINIT 512

// ----------------------------------------------------------------------
// Register port offsets and control fields
// ----------------------------------------------------------------------
`define DDI_RA_CTRL 3'h0
`define DDI_RA_MR0 3'h1
`define DDI_RA_STAT 3'h5
`define DDI_CTRL_INIT 0
`define DDI_CTRL_VSW 1
`define DDI_CTRL_VOK 2
`define DDI_CTRL_UMRS 3
`define DDI_CTRL_TGT 4
`define DDI_CTRL_ODT 6
`define DDI_MR_RST 14'h0000

// ----------------------------------------------------------------------
// Address fields
// ----------------------------------------------------------------------
`define DDI_DLLRST_BIT 8
`define DDI_ZQL_BIT 10

`endif

// File: rtl/ddi_pkg.sv
// Types shared by both ends of the DDR3 init link.
// Assumes nothing beyond a SystemVerilog compiler.
package ddi_pkg;

  // Command pins {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    DDI_CMD_MRS = 4'h0,
    DDI_CMD_ZQCL = 4'h6,
    DDI_CMD_NOP = 4'h7,
    DDI_CMD_DES = 4'hf
  } ddi_cmd_t;

  // Controller sequence states
  typedef enum logic [3:0] {
    DDI_ST_BOOT = 4'h0,
    DDI_ST_RST = 4'h1,
    DDI_ST_CKEL = 4'h2,
    DDI_ST_XPR = 4'h3,
    DDI_ST_MRS = 4'h4,
    DDI_ST_MRW = 4'h5,
    DDI_ST_ZQ = 4'h6,
    DDI_ST_ZQW = 4'h7,
    DDI_ST_RDY = 4'h8,
    DDI_ST_VSW = 4'h9,
    DDI_ST_UMW = 4'ha
  } ddi_state_t;

endpackage

// File: rtl/ddi_if.sv
// Command and control pins between the init controller and the memory.
// Assumes the controller drives every pin; the memory only listens.
`timescale 1ns/10ps
interface ddi_if;
  logic ck;
  logic reset_n;
  logic cke;
  logic odt;
  logic [3:0] cmd;
  logic [2:0] ba;
  logic [13:0] a;

  // Controller drives all pins
  modport ctrl (output ck, reset_n, cke, odt, cmd, ba, a);
  // Memory device samples all pins
  modport dev (input ck, reset_n, cke, odt, cmd, ba, a);
endinterface

// File: rtl/ddi_tmr.sv
// Down-counter for wait intervals, shared by both ends.
// Assumes load and en come from logic on the same clock.
`timescale 1ns/10ps
module ddi_tmr
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Control
  input wire logic load_in,
  input wire logic [16:0] val_in,
  input wire logic en_in,
  // Status
  output logic done_out
);

  logic [16:0] cnt_reg;

  // Load wins over counting so a restart is never lost
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      cnt_reg <= 17'h00000;
    else if (load_in)
      cnt_reg <= val_in;
    else if (en_in && cnt_reg != 17'h00000)
      cnt_reg <= cnt_reg - 17'h00001;
  end

  assign done_out = (cnt_reg == 17'h00000);

endmodule // ddi_tmr

// File: rtl/ddi_dev.sv
// Memory device end: samples the link pins, keeps mode registers,
// tracks DLL lock, the post-MRS busy window and termination state.
// Assumes link pins are asynchronous to MCLK_IN and are synchronised here.
`include "ddi_cfg.svh"
`timescale 1ns/10ps
module ddi_dev
  import ddi_pkg::*;
(
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic RSTN_IN,
  // Memory link
  ddi_if.dev link,
  // Device state
  output logic [55:0] MR_OUT,
  output logic TERM_ON_OUT,
  output logic DLL_LOCK_OUT,
  output logic MODE_BUSY_OUT,
  output logic CKE_SEEN_OUT
);

  localparam int PW = 25;
  logic [PW-1:0] pin_s1_reg, pin_s2_reg;
  logic ck_d_reg, rise, rst_s, cke_s, odt_s, dll_go, dll_done;
  logic [3:0] cmd_s;
  logic [2:0] ba_s;
  logic [13:0] a_s;
  logic [3:0] mod_cnt_reg;
  logic [13:0] mr_reg [4];

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // All pins share one latency so a command stays aligned with its CK edge
  always_ff @(posedge MCLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      ck_d_reg <= 1'b0;
    end
    else
    begin
      pin_s1_reg <= {link.ck, link.reset_n, link.cke, link.odt, link.cmd,
        link.ba, link.a};
      pin_s2_reg <= pin_s1_reg;
      ck_d_reg <= pin_s2_reg[PW-1];
    end
  end

  assign rise = pin_s2_reg[PW-1] && !ck_d_reg;
  assign rst_s = !pin_s2_reg[PW-2];
  assign cke_s = pin_s2_reg[PW-3];
  assign odt_s = pin_s2_reg[PW-4];
  assign cmd_s = pin_s2_reg[20:17];
  assign ba_s = pin_s2_reg[16:14];
  assign a_s = pin_s2_reg[13:0];
  assign dll_go = rise && cke_s && (cmd_s == DDI_CMD_MRS) &&
    (ba_s[1:0] == 2'h0) && a_s[`DDI_DLLRST_BIT];

  // ----------------------------------------------------------------------
  // Mode registers
  // ----------------------------------------------------------------------
  // Contents survive everything but a reset; DLL reset bit is not kept
  always_ff @(posedge MCLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      mr_reg <= '{default: `DDI_MR_RST};
    else if (rst_s)
      mr_reg <= '{default: `DDI_MR_RST};
    else if (rise && cke_s && cmd_s == DDI_CMD_MRS)
    begin
      mr_reg[ba_s[1:0]] <= a_s;
      if (ba_s[1:0] == 2'h0)
        mr_reg[0][`DDI_DLLRST_BIT] <= 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_mr_out
      assign MR_OUT[gi*14 +: 14] = mr_reg[gi];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // CKE, termination and busy window
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      CKE_SEEN_OUT <= 1'b0;
      TERM_ON_OUT <= 1'b0;
      mod_cnt_reg <= 4'h0;
      MODE_BUSY_OUT <= 1'b0;
    end
    else if (rst_s)
    begin
      CKE_SEEN_OUT <= 1'b0;
      TERM_ON_OUT <= 1'b0;
      mod_cnt_reg <= 4'h0;
      MODE_BUSY_OUT <= 1'b0;
    end
    else if (rise)
    begin
      CKE_SEEN_OUT <= CKE_SEEN_OUT | cke_s;
      // Termination follows ODT only after CKE was once registered high
      TERM_ON_OUT <= (CKE_SEEN_OUT | cke_s) && odt_s &&
        (mr_reg[1][2] | mr_reg[1][6] | mr_reg[1][9]);
      if (cke_s && cmd_s == DDI_CMD_MRS)
      begin
        mod_cnt_reg <= 4'(`DDI_NCK_MOD - 1);
        MODE_BUSY_OUT <= 1'b1;
      end
      else if (mod_cnt_reg != 4'h0)
        mod_cnt_reg <= mod_cnt_reg - 4'h1;
      else
        MODE_BUSY_OUT <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // DLL lock
  // ----------------------------------------------------------------------
  // Counts rising CK edges only, so a stopped clock delays lock
  ddi_tmr u_dll
  (
    .clk_in(MCLK_IN),
    .rstn_in(RSTN_IN),
    .load_in(dll_go || rst_s),
    .val_in(17'(`DDI_NCK_DLLK)),
    .en_in(rise && cke_s),
    .done_out(dll_done)
  );

  // Lock is lost at reset and at every DLL reset
  always_ff @(posedge MCLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      DLL_LOCK_OUT <= 1'b0;
    else if (rst_s || dll_go)
      DLL_LOCK_OUT <= 1'b0;
    else if (dll_done && CKE_SEEN_OUT)
      DLL_LOCK_OUT <= 1'b1;
  end

endmodule // ddi_dev

// File: sim/ddi_assertions.sv
// Checker on the link pins between the init controller and the memory.
// Assumes MCLK_IN samples every pin and sits beside the link interface.
`timescale 1ns/10ps
module ddi_assertions
  import ddi_pkg::*;
#(
  parameter int RST_CYC = 40,
  parameter int CKEL_CYC = 60
)
(
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic RSTN_IN,
  // Link pins
  input wire logic ck,
  input wire logic reset_n,
  input wire logic cke,
  input wire logic odt,
  input wire logic [3:0] cmd,
  input wire logic [2:0] ba,
  input wire logic [13:0] a
);
  // ---
  // Helper counters
  // ---
  logic [16:0] low_reg;
  logic [16:0] ckel_reg;
  logic [15:0] since_reg;
  logic [2:0] nmrs_reg;
  logic [3:0] prev_reg;
  logic mrs_go;

  // First cycle of an MRS; the command stands for two cycles
  assign mrs_go = cke && cmd == DDI_CMD_MRS && prev_reg != DDI_CMD_MRS;

  // Pin hold times before reset release and before CKE rise
  always_ff @(posedge MCLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      low_reg <= 17'h0;
      ckel_reg <= 17'h0;
    end
    else
    begin
      low_reg <= reset_n ? 17'h0 : low_reg + 17'h1;
      ckel_reg <= (!reset_n || cke) ? 17'h0 : ckel_reg + 17'h1;
    end
  end

  // MRS count and spacing; saturates so long idle never wraps
  always_ff @(posedge MCLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      since_reg <= 16'hffff;
      nmrs_reg <= 3'h0;
      prev_reg <= DDI_CMD_DES;
    end
    else
    begin
      since_reg <= mrs_go ? 16'h0 : since_reg + 16'(since_reg != 16'hffff);
      nmrs_reg <= !reset_n ? 3'h0 : nmrs_reg + 3'(mrs_go && nmrs_reg < 3'h4);
      prev_reg <= cmd;
    end
  end

  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RSTN_IN);

  a_rst_low_long: assert property (
    $rose(reset_n) |-> low_reg >= RST_CYC)
    else $error("reset released too early");
  a_cke_before_rst: assert property (
    $rose(reset_n) |-> !cke && !$past(cke, 2))
    else $error("cke not low before reset release");
  a_cke_low_long: assert property (
    $rose(cke) |-> ckel_reg >= CKEL_CYC)
    else $error("cke raised too early");
  a_nop_after_cke: assert property (
    $rose(cke) |-> (cmd == DDI_CMD_NOP || cmd == DDI_CMD_DES) [*8])
    else $error("command other than nop after cke rise");
  a_odt_cke_low: assert property (!cke |-> !odt)
    else $error("odt high while cke low");
  a_cke_held: assert property (
    reset_n && $past(cke) && nmrs_reg < 3'h4 |-> cke)
    else $error("cke dropped during init");
  a_first_mr2: assert property (
    mrs_go && nmrs_reg == 3'h0 |-> ba == 3'h2)
    else $error("first mrs not to mr2");
  a_mrs_order: assert property (mrs_go && nmrs_reg < 3'h4 |->
    ba[1:0] == {~nmrs_reg[1], nmrs_reg[1] ^ nmrs_reg[0]} &&
    (nmrs_reg != 3'h3 || a[8]))
    else $error("mrs order wrong");
  a_mrs_gap: assert property (mrs_go |-> since_reg >= 16'd8)
    else $error("mrs spacing too short");
  a_mod_quiet: assert property (
    cke && !(cmd inside {DDI_CMD_NOP, DDI_CMD_DES, DDI_CMD_MRS}) |->
    since_reg >= 16'd24)
    else $error("command inside mode update window");
  a_odt_mod: assert property (
    mrs_go || since_reg < 16'd24 |-> !odt)
    else $error("odt high inside mode update window");
  a_cke_mrs: assert property (mrs_go |-> cke [*8])
    else $error("cke dropped after mrs");

  // Main scenarios reached
  c_user_mrs: cover property (mrs_go && nmrs_reg == 3'h4);
  c_odt_on: cover property (cke && odt);
  c_reinit: cover property ($fell(reset_n));
endmodule // ddi_assertions

// File: sim/test_dram_init_mode_register_sequencing.sv
// Bench: init controller and memory end face each other on the link.
// Assumes shortened reset and CKE-low counts, set by parameters here.
`include "ddi_cfg.svh"
`timescale 1ns/10ps
module test_dram_init_mode_register_sequencing;
  import ddi_pkg::*;
  // ---
  // Signals and instances
  // ---
  localparam int RST_C = 40;
  localparam int CKEL_C = 60;
  logic MCLK_IN = 1'b0;
  logic RSTN_IN = 1'b0;
  logic [2:0] ADDR_IN = 3'h0;
  logic [15:0] WDATA_IN = 16'h0;
  logic WR_IN = 1'b0;
  logic RD_IN = 1'b0;
  logic [15:0] RDATA_OUT;
  logic [15:0] d;
  logic [55:0] MR_OUT;
  logic READY_OUT, TERM_ON_OUT, DLL_LOCK_OUT, MODE_BUSY_OUT, CKE_SEEN_OUT;
  logic [13:0] mr_m [4];
  int n_fail = 0;
  int n_compared = 0;
  int seed = 17491;
  int zq_cyc = 0;

  ddi_if i_ddi_if();
  ddi_ctrl #(.RST_CYC(RST_C), .CKEL_CYC(CKEL_C)) i_ddi_ctrl (.MCLK_IN,
    .RSTN_IN, .ADDR_IN, .WDATA_IN, .WR_IN, .RD_IN, .RDATA_OUT, .READY_OUT,
    .link(i_ddi_if));
  ddi_dev i_ddi_dev (.MCLK_IN, .RSTN_IN, .link(i_ddi_if), .MR_OUT,
    .TERM_ON_OUT, .DLL_LOCK_OUT, .MODE_BUSY_OUT, .CKE_SEEN_OUT);
  ddi_assertions #(.RST_CYC(RST_C), .CKEL_CYC(CKEL_C)) i_ddi_assertions (
    .MCLK_IN, .RSTN_IN, .ck(i_ddi_if.ck), .reset_n(i_ddi_if.reset_n),
    .cke(i_ddi_if.cke), .odt(i_ddi_if.odt), .cmd(i_ddi_if.cmd),
    .ba(i_ddi_if.ba), .a(i_ddi_if.a));

  always #4 MCLK_IN = ~MCLK_IN;

  // Cycles since a long calibration began; restarted only at its start
  always @(posedge MCLK_IN)
    zq_cyc <= (i_ddi_if.cmd == DDI_CMD_ZQCL && zq_cyc > 4) ? 0 : zq_cyc + 1;

  task automatic chk_v(input string nm, input logic [55:0] e,
    input logic [55:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [2:0] ad, input logic [15:0] dt);
    @(posedge MCLK_IN);
    ADDR_IN <= ad;
    WDATA_IN <= dt;
    WR_IN <= 1'b1;
    @(posedge MCLK_IN);
    WR_IN <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] ad, output logic [15:0] dt);
    @(posedge MCLK_IN);
    ADDR_IN <= ad;
    RD_IN <= 1'b1;
    @(posedge MCLK_IN);
    RD_IN <= 1'b0;
    #1 dt = RDATA_OUT;
  endtask

  // Random image; MR0 carries the DLL reset bit, MR1 termination on
  function automatic logic [13:0] img(input int t);
    return 14'($random(seed)) | (t == 0 ? 14'h100 : (t == 1 ? 14'h4 : 14'h0));
  endfunction

  // Device outputs lag the link by a few cycles, so settle before checks
  task automatic await_ready(input logic zq);
    int i;
    logic [55:0] mr_e;
    // A control write stalls the sequencer for one link period, so
    // ready may only drop three edges after the strobe
    repeat (4) @(posedge MCLK_IN);
    for (i = 0; i < 4000 && READY_OUT !== 1'b1; i++)
      @(posedge MCLK_IN);
    chk_v("ready", 56'h1, 56'(READY_OUT));
    if (zq)
      chk_v("zq wait", 56'h1, 56'(zq_cyc >= 2 * `DDI_NCK_ZQINIT));
    repeat (8) @(posedge MCLK_IN);
    mr_e = {mr_m[3], mr_m[2], mr_m[1], mr_m[0] & 14'h3eff};
    chk_v("mode regs", mr_e, MR_OUT);
    chk_v("dll lock", 56'h1, 56'(DLL_LOCK_OUT));
    chk_v("busy", 56'h0, 56'(MODE_BUSY_OUT));
  endtask

  task automatic stop_test();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ---
  // Scenarios
  // ---
  initial
  begin
    repeat (4) @(posedge MCLK_IN);
    RSTN_IN <= 1'b1;
    wr(`DDI_RA_CTRL, 16'h40);
    for (int t = 0; t < 4; t++)
    begin
      mr_m[t] = img(t);
      wr(3'(t + 1), {2'h0, mr_m[t]});
      rd(3'(t + 1), d);
      chk_v("image", 56'(mr_m[t]), 56'(d[13:0]));
    end
    for (int u = 6; u < 8; u++)
    begin
      rd(3'(u), d);
      chk_v("unmapped", 56'h0, 56'(d));
    end
    chk_v("term early", 56'h0, 56'(TERM_ON_OUT));
    await_ready(1'b1);
    chk_v("term on", 56'h1, 56'(TERM_ON_OUT));
    rd(`DDI_RA_STAT, d);
    chk_v("status", 56'(DDI_ST_RDY), 56'(d[3:0]));
    // Single mode-register writes to every target
    for (int t = 0; t < 4; t++)
    begin
      mr_m[t] = img(t) & 14'h3eff;
      wr(3'(t + 1), {2'h0, mr_m[t]});
      wr(`DDI_RA_CTRL, 16'h48 | 16'(t << 4));
      repeat (12) @(posedge MCLK_IN);
      chk_v("busy on", 56'h1, 56'(MODE_BUSY_OUT));
      await_ready(1'b0);
    end
    // Supply switch: only idle commands until the level is stable
    wr(`DDI_RA_CTRL, 16'h42);
    repeat (4) @(posedge MCLK_IN);
    chk_v("switch ready", 56'h0, 56'(READY_OUT));
    for (int k = 0; k < 40; k++)
    begin
      @(posedge MCLK_IN);
      chk_v("quiet cmd", 56'hf, 56'(i_ddi_if.cmd | 4'h8));
    end
    wr(`DDI_RA_CTRL, 16'h44);
    repeat (40) @(posedge MCLK_IN);
    chk_v("dll relock", 56'h0, 56'(DLL_LOCK_OUT));
    await_ready(1'b1);
    // Re-init clears the device mode registers
    wr(`DDI_RA_CTRL, 16'h1);
    repeat (10) @(posedge MCLK_IN);
    chk_v("mode regs cleared", 56'h0, MR_OUT);
    chk_v("cke seen", 56'h0, 56'(CKE_SEEN_OUT));
    await_ready(1'b1);
    stop_test();
  end

  // Cut a hang short; the full run needs about 3700 cycles
  initial
  begin
    #100000;
    n_fail++;
    stop_test();
  end
endmodule // test_dram_init_mode_register_sequencing
